// >>> common/rwcm_cfg.svh
// constants for the reset, watchdog and clock monitor block
// Overview of operation
// - Reset comes from power-on, the reset pin, watchdog expiry or clock monitor.
// - After power-on wait a settle delay, then stay in reset while pin low.
// - The power-on reset pulls the reset pin low through an open-drain driver.
// - A pin low for at least 8 cycles resets the device.
// - Watchdog expiry resets the device and drives the reset pin low.
// - Fail flag bit 4 set on watchdog or clock monitor reset only.
// - Reading the control register clears the fail flag.
// - Watchdog enable bit 2 takes only the first write after reset.
// - Select bits 1 and 0 pick one of four timeout periods.
// - Timeout is 2^15 bus clocks times 1, 4, 16 or 64.
// - Select bits clear at reset and take a single write per reset.
// - With enable bit 3 set, a slow or absent clock resets and drives pin.
// - No trigger above about 200 kHz; trigger when stopped or below about 5 kHz.
// - Clock monitor enable is freely readable and writable.
// - An enabled clock monitor resets the device when halt mode is entered.
// - Control bits 7 to 5 read zero; the register resets to 00.
`ifndef RWCM_CFG_SVH
`define RWCM_CFG_SVH
`define RWCM_IDX_CONTROL 8'h1E
`define RWCM_IDX_SERVICE 8'h1F
`define RWCM_IDX_IRQ_STATUS 8'h20
`define RWCM_IDX_IRQ_CLEAR 8'h21
`define RWCM_IDX_IRQ_ENABLE 8'h22
`define RWCM_BIT_FAIL 4
`define RWCM_BIT_CLKCHK 3
`define RWCM_BIT_WDG_EN 2
`define RWCM_BIT_SEL_HI 1
`define RWCM_BIT_SEL_LO 0
`define RWCM_CONTROL_RESET 8'h00
`define RWCM_SERVICE_ARM 8'h55
`define RWCM_SERVICE_FIRE 8'hAA
`define RWCM_IRQ_WDG 0
`define RWCM_IRQ_CLKMON 1
`define RWCM_IRQ_PIN 2
`define RWCM_IRQ_BITS 3
`define RWCM_CLK_MHZ 125
`define RWCM_WDG_BASE 32768
`define RWCM_PIN_MIN_CYC 8
`define RWCM_DRIVE_CYC 16
`define RWCM_POR_NS 32768
`define RWCM_CM_LIMIT_NS 100000
`endif

// >>> common/rwcm_pkg.sv
// types for the reset, watchdog and clock monitor block
package rwcm_pkg;
    typedef enum logic [1:0] {
        RWCM_ST_POR,
        RWCM_ST_PIN,
        RWCM_ST_RUN,
        RWCM_ST_DRIVE
    } rwcm_state_e;
endpackage : rwcm_pkg

// >>> design/rwcm_top.sv
// reset sequencer, watchdog, clock monitor and their registers
`timescale 1ns/1ps
`include "rwcm_cfg.svh"
module rwcm_top #(
    parameter int WDG_BASE = `RWCM_WDG_BASE,
    parameter int POR_CYC = (`RWCM_POR_NS * `RWCM_CLK_MHZ + 999) / 1000,
    parameter int CM_LIMIT_CYC = (`RWCM_CM_LIMIT_NS * `RWCM_CLK_MHZ) / 1000
) (
    // clock and power-on reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // reset pin, open drain
    input wire logic i_reset_pin,
    output logic o_reset_pin_out,
    output logic o_reset_pin_oe,
    // monitored bus clock and halt mode
    input wire logic i_bus_clock_ref,
    input wire logic i_halt,
    // system reset and interrupt
    output logic o_sys_reset_n,
    output logic o_irq
);
    localparam int WDG_W = $clog2(WDG_BASE * 64 + 1);
    localparam int POR_W = $clog2(POR_CYC + 1);
    localparam int CM_W = $clog2(CM_LIMIT_CYC + 1);

    initial begin
        if (WDG_BASE < 1 || POR_CYC < 1 || CM_LIMIT_CYC < 2) begin
            $error("rwcm_top: counts must be positive");
        end
        // the longest timeout must fit a signed count
        if (WDG_BASE > 32'h0100_0000) begin
            $error("rwcm_top: watchdog base too large");
        end
        // fixed-width pin filter and drive counters
        if (`RWCM_PIN_MIN_CYC > 32'hF || `RWCM_DRIVE_CYC > 32'h1F) begin
            $error("rwcm_top: pin or drive count too wide");
        end
    end

    // timeout limit from the select bits
    function automatic logic [WDG_W-1:0] wdg_limit(input logic [1:0] sel);
        logic [WDG_W-1:0] base;
        base = WDG_W'(WDG_BASE);
        case (sel)
            2'h0: wdg_limit = base;
            2'h1: wdg_limit = base << 2;
            2'h2: wdg_limit = base << 4;
            default: wdg_limit = base << 6;
        endcase
    endfunction : wdg_limit

    // byte address decode of a register index
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
        hit = (addr == {idx[5:0], 2'h0}) && (idx[7:6] == 2'h0);
    endfunction : hit

    rwcm_pkg::rwcm_state_e state;
    logic [POR_W-1:0] por_cnt;
    logic [3:0] pin_cnt;
    logic [4:0] drv_cnt;
    logic [WDG_W-1:0] wdg_cnt;
    logic [CM_W-1:0] cm_cnt;
    logic ref_q;
    logic ack;
    logic fail_flag;
    logic clkchk_en;
    logic wdg_en;
    logic [1:0] sel;
    logic wdg_en_wr;
    logic sel_wr;
    logic armed;
    logic [`RWCM_IRQ_BITS-1:0] irq_status;
    logic [`RWCM_IRQ_BITS-1:0] irq_enable;
    logic req;
    logic do_wr;
    logic do_rd;
    logic running;
    logic wdg_expire;
    logic cm_fault;
    logic pin_reset;
    logic service;
    logic [7:0] wbyte;
    logic [7:0] control_rd;
    logic [`RWCM_IRQ_BITS-1:0] ev;

    // bus handshake, one wait state
    assign req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack;
    assign do_wr = i_avs_write & ack & i_avs_byteenable[0];
    assign do_rd = i_avs_read & ack;
    assign wbyte = i_avs_writedata[7:0];
    assign running = (state == rwcm_pkg::RWCM_ST_RUN);
    assign control_rd = {3'h0, fail_flag, clkchk_en, wdg_en, sel};
    assign service = do_wr && hit(i_avs_address, `RWCM_IDX_SERVICE)
        && wbyte == `RWCM_SERVICE_FIRE && armed;
    assign wdg_expire = running && wdg_en && (wdg_cnt >= wdg_limit(sel) - WDG_W'(1));
    // no edge within the slow limit
    assign cm_fault = running && clkchk_en && (cm_cnt >= CM_W'(CM_LIMIT_CYC - 1));
    // pin low for the minimum time
    assign pin_reset = running && (pin_cnt >= 4'(`RWCM_PIN_MIN_CYC - 1)) && !i_reset_pin;
    assign ev = {pin_reset, cm_fault, wdg_expire};

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // read data captured before the answer cycle
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_avs_readdata <= 32'h0;
        end else if (i_avs_read && !ack) begin
            if (hit(i_avs_address, `RWCM_IDX_CONTROL)) begin
                o_avs_readdata <= {24'h0, control_rd};
            end else if (hit(i_avs_address, `RWCM_IDX_IRQ_STATUS)) begin
                o_avs_readdata <= {29'h0, irq_status};
            end else if (hit(i_avs_address, `RWCM_IDX_IRQ_ENABLE)) begin
                o_avs_readdata <= {29'h0, irq_enable};
            end else begin
                o_avs_readdata <= 32'h0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= rwcm_pkg::RWCM_ST_POR;
            por_cnt <= '0;
            drv_cnt <= 5'h0;
        end else begin
            case (state)
                rwcm_pkg::RWCM_ST_POR: begin
                    if (por_cnt >= POR_W'(POR_CYC - 1)) begin
                        state <= rwcm_pkg::RWCM_ST_PIN;
                    end else begin
                        por_cnt <= por_cnt + POR_W'(1);
                    end
                end
                rwcm_pkg::RWCM_ST_PIN: begin
                    if (i_reset_pin) begin
                        state <= rwcm_pkg::RWCM_ST_RUN;
                    end
                end
                rwcm_pkg::RWCM_ST_RUN: begin
                    if (wdg_expire || cm_fault) begin
                        state <= rwcm_pkg::RWCM_ST_DRIVE;
                        drv_cnt <= 5'h0;
                    end else if (pin_reset) begin
                        state <= rwcm_pkg::RWCM_ST_PIN;
                    end
                end
                rwcm_pkg::RWCM_ST_DRIVE: begin
                    if (drv_cnt >= 5'(`RWCM_DRIVE_CYC - 1)) begin
                        state <= rwcm_pkg::RWCM_ST_PIN;
                    end else begin
                        drv_cnt <= drv_cnt + 5'h1;
                    end
                end
                default: begin
                    state <= rwcm_pkg::RWCM_ST_POR;
                end
            endcase
        end
    end

    // pin driven low on internal reset
    assign o_reset_pin_out = 1'b0;
    assign o_reset_pin_oe = (state == rwcm_pkg::RWCM_ST_POR)
        || (state == rwcm_pkg::RWCM_ST_DRIVE);
    assign o_sys_reset_n = running;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_cnt <= 4'h0;
        end else if (!running || i_reset_pin) begin
            pin_cnt <= 4'h0;
        end else if (pin_cnt < 4'(`RWCM_PIN_MIN_CYC - 1)) begin
            pin_cnt <= pin_cnt + 4'h1;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            armed <= 1'b0;
        end else if (!running) begin
            armed <= 1'b0;
        end else if (do_wr && hit(i_avs_address, `RWCM_IDX_SERVICE)) begin
            armed <= (wbyte == `RWCM_SERVICE_ARM);
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wdg_cnt <= '0;
        end else if (!running || service) begin
            wdg_cnt <= '0;
        end else if (wdg_cnt < wdg_limit(sel)) begin
            wdg_cnt <= wdg_cnt + WDG_W'(1);
        end
    end

    // edge gap count, halt stops the clock
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ref_q <= 1'b0;
            cm_cnt <= '0;
        end else begin
            ref_q <= i_bus_clock_ref;
            if (!running || (ref_q != i_bus_clock_ref && !i_halt)) begin
                cm_cnt <= '0;
            end else if (cm_cnt < CM_W'(CM_LIMIT_CYC - 1)) begin
                cm_cnt <= cm_cnt + CM_W'(1);
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fail_flag <= 1'(`RWCM_CONTROL_RESET >> `RWCM_BIT_FAIL);
        end else if (wdg_expire || cm_fault) begin
            fail_flag <= 1'b1;
        end else if (do_rd && hit(i_avs_address, `RWCM_IDX_CONTROL)) begin
            fail_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clkchk_en <= 1'b0;
            wdg_en <= 1'b0;
            sel <= 2'h0;
            wdg_en_wr <= 1'b0;
            sel_wr <= 1'b0;
        end else if (!running) begin
            clkchk_en <= 1'b0;
            wdg_en <= 1'b0;
            sel <= 2'h0;
            wdg_en_wr <= 1'b0;
            sel_wr <= 1'b0;
        end else if (do_wr && hit(i_avs_address, `RWCM_IDX_CONTROL)) begin
            clkchk_en <= wbyte[`RWCM_BIT_CLKCHK];
            wdg_en_wr <= 1'b1;
            sel_wr <= 1'b1;
            if (!wdg_en_wr) begin
                wdg_en <= wbyte[`RWCM_BIT_WDG_EN];
            end
            if (!sel_wr) begin
                sel <= {wbyte[`RWCM_BIT_SEL_HI], wbyte[`RWCM_BIT_SEL_LO]};
            end
        end
    end

    // interrupt status, set wins over clear
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_status <= '0;
        end else if (do_wr && hit(i_avs_address, `RWCM_IDX_IRQ_CLEAR)) begin
            irq_status <= (irq_status & ~wbyte[`RWCM_IRQ_BITS-1:0]) | ev;
        end else begin
            irq_status <= irq_status | ev;
        end
    end

    // interrupt enable register
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_enable <= '0;
        end else if (do_wr && hit(i_avs_address, `RWCM_IDX_IRQ_ENABLE)) begin
            irq_enable <= wbyte[`RWCM_IRQ_BITS-1:0];
        end
    end

    // level interrupt while an enabled bit is set
    assign o_irq = |(irq_status & irq_enable);
endmodule : rwcm_top

// >>> verif/rwcm_top_assertions.sv
// port-level checks for the reset sequencer and watchdog block
`timescale 1ns/1ps
module rwcm_top_assertions (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // register bus
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // reset pin and system reset
    input wire logic i_reset_pin,
    input wire logic o_reset_pin_out,
    input wire logic o_reset_pin_oe,
    input wire logic o_sys_reset_n,
    input wire logic o_irq
);
    logic [3:0] low_cnt;
    logic ctl_seen;
    logic ctl_ans;
    assign ctl_ans = i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h78;
    // counts consecutive low samples of the pin
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) low_cnt <= 4'h0;
        else if (i_reset_pin) low_cnt <= 4'h0;
        else if (low_cnt != 4'hF) low_cnt <= low_cnt + 4'h1;
    end
    // marks a control read since the last reset
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) ctl_seen <= 1'b0;
        else if (!o_sys_reset_n) ctl_seen <= 1'b0;
        else if (ctl_ans) ctl_seen <= 1'b1;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    upper_zero_a: assert property (i_avs_read && !o_avs_waitrequest
        |-> o_avs_readdata[31:5] == 27'h0) else $error("upper read bits set");
    pin_safe_a: assert property (o_reset_pin_oe
        |-> !o_sys_reset_n && !o_reset_pin_out) else $error("pin driven outside reset");
    por_drive_a: assert property ($rose(i_arst_n)
        |-> o_reset_pin_oe [*3]) else $error("pin not pulled at power-up");
    pin_min_a: assert property ($fell(o_sys_reset_n) && !o_reset_pin_oe
        |-> low_cnt >= 4'h8) else $error("pin reset too early");
    pin_enter_a: assert property ((o_sys_reset_n && !i_reset_pin) [*8]
        |=> !o_sys_reset_n) else $error("pin reset missed");
    drive_len_a: assert property ($rose(o_reset_pin_oe)
        |-> o_reset_pin_oe [*8]) else $error("pin drive too short");
    pin_exit_a: assert property (!o_sys_reset_n && !o_reset_pin_oe && i_reset_pin
        |=> o_sys_reset_n) else $error("reset not left");
    stay_reset_a: assert property (!o_sys_reset_n && !o_reset_pin_oe && !i_reset_pin
        |=> !o_sys_reset_n) else $error("reset left with pin low");
    fail_clear_a: assert property (ctl_ans && ctl_seen
        |-> !o_avs_readdata[4]) else $error("fail flag not cleared");
    cover property ($fell(o_sys_reset_n) && o_reset_pin_oe);
    cover property ($fell(o_sys_reset_n) && !o_reset_pin_oe);
    cover property ($rose(o_irq));
endmodule : rwcm_top_assertions

// >>> verif/rwcm_ext_model.sv
// external reset circuit and monitored clock source
`timescale 1ns/1ps
module rwcm_ext_model (
    // clock and controls
    input wire logic i_clock,
    input wire logic i_dut_oe,
    input wire logic i_pull_low,
    input wire logic i_ref_run,
    // wire and reference
    output logic o_pin_wire,
    output logic o_ref_clock
);
    logic [1:0] div = 2'h0;
    logic ref_q = 1'b0;
    assign o_pin_wire = ~(i_dut_oe | i_pull_low);
    assign o_ref_clock = ref_q;
    always_ff @(posedge i_clock) begin
        if (i_ref_run) begin
            div <= div + 2'h1;
            if (div == 2'h3) ref_q <= ~ref_q;
        end
    end
endmodule : rwcm_ext_model

// >>> verif/rwcm_top_test.sv
// self-checking bench for the reset and watchdog block
`timescale 1ns/1ps
module rwcm_top_test;
    logic i_clock = 1'b0;
    logic i_arst_n = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [7:0] wd = 8'h00;
    logic halt = 1'b0;
    logic pull = 1'b0;
    logic run = 1'b1;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic wait_r, pin_out, pin_oe, sys_n, irq, pin, ref_clk;
    int mismatches = 0;
    int total_checks = 0;
    int n;
    always #4 i_clock = ~i_clock;
    rwcm_top #(.WDG_BASE(16), .POR_CYC(4), .CM_LIMIT_CYC(16)) dut (.i_clock(i_clock),
        .i_arst_n(i_arst_n), .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s),
        .i_avs_writedata({24'h0, wd}), .i_avs_byteenable(4'h1), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_r), .i_reset_pin(pin), .o_reset_pin_out(pin_out),
        .o_reset_pin_oe(pin_oe), .i_bus_clock_ref(ref_clk), .i_halt(halt),
        .o_sys_reset_n(sys_n), .o_irq(irq));
    rwcm_ext_model ext (.i_clock(i_clock), .i_dut_oe(pin_oe), .i_pull_low(pull),
        .i_ref_run(run), .o_pin_wire(pin), .o_ref_clock(ref_clk));
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic hang();
        chk(32'h0, 32'h1);
        test_done();
    endtask : hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge i_clock);
        adr <= a;
        wd <= d;
        wr_s <= w;
        rd_s <= ~w;
        // waitrequest and read data are taken at the same rising edge
        for (k = 0; k < 20; k++) begin
            @(posedge i_clock);
            if (wait_r === 1'b0) break;
        end
        rd = rdata;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        if (k == 20) hang();
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask : rchk
    task automatic pchk(input logic [2:0] m, input logic [2:0] e);
        @(negedge i_clock);
        chk({29'h0, {sys_n, pin, irq} & m}, {29'h0, e});
    endtask : pchk
    task automatic wsys(input logic lvl, input int lim);
        for (n = 0; n < lim; n++) begin
            @(negedge i_clock);
            if (sys_n === lvl) return;
        end
        hang();
    endtask : wsys
    task automatic boot();
        @(posedge i_clock);
        i_arst_n <= 1'b0;
        repeat (16) @(posedge i_clock);
        i_arst_n <= 1'b1;
        pchk(3'b010, 3'b000);
        wsys(1'b1, 40);
    endtask : boot
    initial begin
        boot();
        rchk(8'h78, 8'h00);
        rchk(8'hFC, 8'h00);
        bus(1'b1, 8'h78, 8'hFF);
        rchk(8'h78, 8'h0F);
        bus(1'b1, 8'h78, 8'h02);
        rchk(8'h78, 8'h07);
        repeat (200) begin
            bus(1'b1, 8'h7C, 8'h55);
            bus(1'b1, 8'h7C, 8'hAA);
        end
        pchk(3'b100, 3'b100);
        for (int i = 0; i < 400 && sys_n === 1'b1; i++) bus(1'b1, 8'h7C, 8'hAA);
        pchk(3'b110, 3'b000);
        wsys(1'b1, 60);
        rchk(8'h78, 8'h10);
        rchk(8'h78, 8'h00);
        rchk(8'h80, 8'h01);
        bus(1'b1, 8'h88, 8'h01);
        pchk(3'b001, 3'b001);
        bus(1'b1, 8'h84, 8'h01);
        rchk(8'h80, 8'h00);
        pchk(3'b001, 3'b000);
        @(posedge i_clock);
        pull <= 1'b1;
        repeat (7) @(posedge i_clock);
        pull <= 1'b0;
        repeat (3) @(posedge i_clock);
        pchk(3'b100, 3'b100);
        @(posedge i_clock);
        pull <= 1'b1;
        repeat (8) @(posedge i_clock);
        pchk(3'b100, 3'b000);
        @(posedge i_clock);
        pull <= 1'b0;
        wsys(1'b1, 10);
        rchk(8'h78, 8'h00);
        rchk(8'h80, 8'h04);
        pchk(3'b001, 3'b000);
        bus(1'b1, 8'h78, 8'h08);
        repeat (40) @(posedge i_clock);
        pchk(3'b100, 3'b100);
        @(posedge i_clock);
        run <= 1'b0;
        wsys(1'b0, 40);
        pchk(3'b010, 3'b000);
        @(posedge i_clock);
        run <= 1'b1;
        wsys(1'b1, 60);
        rchk(8'h78, 8'h10);
        bus(1'b1, 8'h78, 8'h08);
        @(posedge i_clock);
        halt <= 1'b1;
        wsys(1'b0, 40);
        @(posedge i_clock);
        halt <= 1'b0;
        wsys(1'b1, 60);
        rchk(8'h78, 8'h10);
        bus(1'b1, 8'h78, 8'h08);
        bus(1'b1, 8'h78, 8'h00);
        @(posedge i_clock);
        halt <= 1'b1;
        repeat (40) @(posedge i_clock);
        pchk(3'b100, 3'b100);
        @(posedge i_clock);
        halt <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            boot();
            bus(1'b1, 8'h78, 8'h04 | 8'(s));
            bus(1'b1, 8'h7C, 8'h55);
            bus(1'b1, 8'h7C, 8'hAA);
            wsys(1'b0, 1100);
            chk({31'h0, n >= (16 << 2 * s) - 2 && n <= (16 << 2 * s) + 2}, 32'h1);
        end
        test_done();
    end
endmodule : rwcm_top_test
bind rwcm_top rwcm_top_assertions chk_u (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_reset_pin(i_reset_pin), .o_reset_pin_out(o_reset_pin_out),
    .o_reset_pin_oe(o_reset_pin_oe), .o_sys_reset_n(o_sys_reset_n), .o_irq(o_irq));
